// ### rtcp_consts.vh
/*
  constants for the slow-domain power management block: register offset,
  field positions, reset values and timing counts.
  assumes a 200 MHz bus clock and a 32.768 kHz slow clock sampled as a level.
*/
// Functional notes
// - shutdown bit write turns regulator off, isolates
// - wake high ramps regulator, then supply ok
// - bits fifteen to five read zero
// - wake out value zero drives pin low
// - direction bit selects input or open drain
// - reference shutdown also stops bandgap reference
// - regulator shutdown keeps bandgap reference running
// - wake pin or alarm re-enables circuits
// - clock output enable bit gates clock out
// - writes land two slow cycles later
// - slow domain reset only by own reset
`ifndef RTCP_CONSTS_VH
`define RTCP_CONSTS_VH

`define RTCP_ADDR_W          16
`define RTCP_PMGT_OFFSET     16'h1930
`define RTCP_CLKOUT_BIT      0
`define RTCP_REG_SD_BIT      1
`define RTCP_REF_SD_BIT      2
`define RTCP_WAKE_DIR_BIT    3
`define RTCP_WAKE_OUT_BIT    4
`define RTCP_FIELD_W         5
`define RTCP_PMGT_RESET      5'h10
`define RTCP_CLK_PERIOD_PS   5000
`define RTCP_SLOW_PERIOD_NS  30518
`define RTCP_SLOW_CYCLES     ((`RTCP_SLOW_PERIOD_NS * 1000) / `RTCP_CLK_PERIOD_PS)
`define RTCP_WAKE_MIN_NS     30500
`define RTCP_WAKE_MIN_CYC    ((`RTCP_WAKE_MIN_NS * 1000 + `RTCP_CLK_PERIOD_PS - 1) / `RTCP_CLK_PERIOD_PS)
`define RTCP_RAMP_NS         10000
`define RTCP_RAMP_CYC        ((`RTCP_RAMP_NS * 1000) / `RTCP_CLK_PERIOD_PS)

`endif

// ### rtcp_edge_sync.v
/*
  two-stage synchroniser with rising-edge output, used to follow the slow
  clock level inside the bus clock domain.
  assumes the input is a free level with no relation to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcp_edge_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire d_i,
  output wire level_o,
  output wire rise_o
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;
  reg [2:0] fill_reg;   // stages that already hold a real sample

  // first stage feeds only the second one
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      fill_reg <= 3'h0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      fill_reg <= {fill_reg[1:0], 1'b1};
    end
  end

  assign level_o = sync_reg;
  // no edge until the pipe is filled: a high input at reset is not a rise
  assign rise_o  = sync_reg & ~last_reg & fill_reg[2];
endmodule // rtcp_edge_sync
`default_nettype wire

// ### rtcp_power_ctrl.v
/*
  power management control for clock-only low-power mode: one register,
  wake pin control, regulator and reference shutdown, supply-ok sequencing,
  slow clock output gating.
  assumes the bus master keeps one-cycle strobes; slow_clk_i is a level;
  por_i is the slow domain's own power-on reset, rst_i only the bus side.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcp_consts.vh"
module rtcp_power_ctrl #(
  parameter RAMP_CYCLES = `RTCP_RAMP_CYC,
  parameter WAKE_CYCLES = `RTCP_WAKE_MIN_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        por_i,
  input  wire [15:0] addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire        slow_clk_i,
  input  wire        alarm_i,
  input  wire        wake_pin_i,
  output reg         wake_pin_o,
  output reg         wake_pin_oe_n_o,
  output reg         core_regulator_output_o,
  output reg         bandgap_on_o,
  output reg         analog_por_on_o,
  output reg         supply_ok_o,
  output reg         system_reset_o,
  output reg         slow_clock_out_o
);
  localparam ST_ON   = 2'd0;
  localparam ST_OFF  = 2'd1;
  localparam ST_RAMP = 2'd2;
  localparam ST_REL  = 2'd3;

  wire slow_level;
  wire slow_rise;
  reg  [`RTCP_FIELD_W-1:0] pm_reg;      // applied register contents
  reg  [`RTCP_FIELD_W-1:0] pend_reg;    // written value awaiting slow edges
  reg  [1:0]  pend_cnt_reg;
  reg         pend_reg_valid;
  reg  [1:0]  state_reg;
  reg  [31:0] ramp_cnt_reg;
  reg  [31:0] wake_cnt_reg;
  reg         sd_pending_reg;

  rtcp_edge_sync rtcp_edge_sync_i (
    .clk_i   (clk_i),
    .rst_i   (por_i),
    .d_i     (slow_clk_i),
    .level_o (slow_level),
    .rise_o  (slow_rise)
  );

  function hit;
    input [15:0] a;
    begin
      hit = (a == `RTCP_PMGT_OFFSET);
    end
  endfunction

  wire wake_in_mode = ~pm_reg[`RTCP_WAKE_DIR_BIT];
  wire wake_high    = wake_in_mode & wake_pin_i;
  // held pin wakes only after one slow period of width, short glitches ignored
  wire wake_seen    = wake_high && (wake_cnt_reg >= WAKE_CYCLES - 1);
  wire access_ok    = supply_ok_o;

  // register slot: write parked, applied on the second slow rising edge
  always @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      pm_reg         <= `RTCP_PMGT_RESET;
      pend_reg       <= `RTCP_PMGT_RESET;
      pend_cnt_reg   <= 2'd0;
      pend_reg_valid <= 1'b0;
    end else begin
      if (wr_i && access_ok && hit(addr_i)) begin
        pend_reg       <= wdata_i[`RTCP_FIELD_W-1:0];
        pend_reg_valid <= 1'b1;
        pend_cnt_reg   <= 2'd0;
      end else if (pend_reg_valid && slow_rise) begin
        if (pend_cnt_reg == 2'd1) begin
          pm_reg         <= pend_reg;
          pend_reg_valid <= 1'b0;
        end else begin
          pend_cnt_reg <= pend_cnt_reg + 2'd1;
        end
      end
      // wake-up clears the shutdown requests so power stays up
      if (state_reg == ST_REL) begin
        pm_reg[`RTCP_REG_SD_BIT] <= 1'b0;
        pm_reg[`RTCP_REF_SD_BIT] <= 1'b0;
      end
    end
  end

  // width of a wake pulse, counted in bus cycles
  always @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      wake_cnt_reg <= 32'd0;
    end else if (!wake_high) begin
      wake_cnt_reg <= 32'd0;
    end else if (wake_cnt_reg < WAKE_CYCLES) begin
      wake_cnt_reg <= wake_cnt_reg + 32'd1;
    end
  end

  // power sequence: on, shut down, ramping, release of reset
  always @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      state_reg      <= ST_ON;
      ramp_cnt_reg   <= 32'd0;
      sd_pending_reg <= 1'b0;
    end else begin
      // the release cycle clears the request bits, so it must not re-arm a shutdown
      sd_pending_reg <= (state_reg != ST_REL) &
                        (pm_reg[`RTCP_REG_SD_BIT] | pm_reg[`RTCP_REF_SD_BIT]);
      case (state_reg)
        ST_ON: begin
          if (sd_pending_reg) begin
            state_reg <= ST_OFF;
          end
        end
        ST_OFF: begin
          if (wake_seen || alarm_i) begin
            state_reg    <= ST_RAMP;
            ramp_cnt_reg <= 32'd0;
          end
        end
        ST_RAMP: begin
          // supply-ok stays low until the regulator reaches threshold
          if (ramp_cnt_reg >= RAMP_CYCLES - 1) begin
            state_reg <= ST_REL;
          end else begin
            ramp_cnt_reg <= ramp_cnt_reg + 32'd1;
          end
        end
        ST_REL: begin
          state_reg <= ST_ON;
        end
        default: begin
          state_reg <= ST_ON;
        end
      endcase
    end
  end

  // analog controls and pins, all from flops
  always @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      core_regulator_output_o <= 1'b1;
      bandgap_on_o            <= 1'b1;
      analog_por_on_o         <= 1'b1;
      supply_ok_o             <= 1'b1;
      system_reset_o          <= 1'b0;
      wake_pin_o              <= 1'b0;
      wake_pin_oe_n_o         <= 1'b1;
      slow_clock_out_o        <= 1'b0;
    end else begin
      core_regulator_output_o <= (state_reg != ST_OFF);
      analog_por_on_o         <= (state_reg != ST_OFF);
      // reference shutdown also drops the bandgap, reg shutdown alone keeps it
      bandgap_on_o <= !((state_reg == ST_OFF) && pm_reg[`RTCP_REF_SD_BIT]);
      supply_ok_o    <= (state_reg == ST_ON) || (state_reg == ST_REL);
      system_reset_o <= (state_reg == ST_REL);
      wake_pin_o     <= 1'b0;                                // open drain only pulls low
      wake_pin_oe_n_o <= ~(pm_reg[`RTCP_WAKE_DIR_BIT] &
                           ~pm_reg[`RTCP_WAKE_OUT_BIT]);
      slow_clock_out_o <= pm_reg[`RTCP_CLKOUT_BIT] & slow_level;
    end
  end

  // read port: data the cycle after the strobe, zero elsewhere
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i && access_ok && hit(addr_i)) begin
      rdata_o <= {11'h000, pm_reg};
    end else begin
      rdata_o <= 16'h0000;
    end
  end
endmodule // rtcp_power_ctrl
`default_nettype wire

// ### rtcp_power_ctrl_props.sv
/* checker on the power control ports.
   assumes a short ramp parameter, so power returns within 40 clocks of a wake. */
`timescale 1ns/1ps
`default_nettype none
module rtcp_power_ctrl_props #(
  parameter int RAMP_CYCLES = 8,
  parameter int WAKE_CYCLES = 4
) (
  input wire logic        clk_i,
  input wire logic        por_i,
  input wire logic        alarm_i,
  input wire logic        rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] rdata_o,
  input wire logic        wake_pin_o,
  input wire logic        wake_pin_oe_n_o,
  input wire logic        core_regulator_output_o,
  input wire logic        bandgap_on_o,
  input wire logic        analog_por_on_o,
  input wire logic        supply_ok_o,
  input wire logic        system_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (por_i);
  // alarm seen while isolated, then power back inside the short ramp
  sequence s_alarm_off; !supply_ok_o && alarm_i; endsequence
  sequence s_powered; ##[1:40] supply_ok_o; endsequence
  property p_rsvd; rd_i |=> rdata_o[15:5] == 11'h000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_block; rd_i && (addr_i != 16'h1930 || !supply_ok_o) |=> rdata_o == 16'h0000;
  endproperty
  a_block: assert property (p_block) else $error("refused read gave data");
  property p_od; !wake_pin_oe_n_o |-> !wake_pin_o; endproperty
  a_od: assert property (p_od) else $error("wake pin driven high");
  property p_iso; !core_regulator_output_o |-> !supply_ok_o && !analog_por_on_o; endproperty
  a_iso: assert property (p_iso) else $error("isolation missing");
  property p_ref; !bandgap_on_o |-> !core_regulator_output_o && !analog_por_on_o; endproperty
  a_ref: assert property (p_ref) else $error("reference off alone");
  property p_rel; $rose(supply_ok_o) |-> system_reset_o && core_regulator_output_o;
  endproperty
  a_rel: assert property (p_rel) else $error("no reset on power return");
  property p_pulse; system_reset_o |=> !system_reset_o; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_alarm; s_alarm_off |-> s_powered; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm did not wake");
endmodule // rtcp_power_ctrl_props
bind rtcp_power_ctrl rtcp_power_ctrl_props #(.RAMP_CYCLES(RAMP_CYCLES), .WAKE_CYCLES(WAKE_CYCLES))
  rtcp_power_ctrl_props_i (.clk_i(clk_i), .por_i(por_i), .alarm_i(alarm_i), .rd_i(rd_i),
  .addr_i(addr_i), .rdata_o(rdata_o), .wake_pin_o(wake_pin_o),
  .wake_pin_oe_n_o(wake_pin_oe_n_o), .core_regulator_output_o(core_regulator_output_o),
  .bandgap_on_o(bandgap_on_o), .analog_por_on_o(analog_por_on_o),
  .supply_ok_o(supply_ok_o), .system_reset_o(system_reset_o));
`default_nettype wire

// ### rtcp_power_ctrl_tb.sv
/* register-level test of the power control block.
   assumes a scaled slow clock of 40 bus clocks, short ramp and wake counts. */
`timescale 1ns/1ps
`default_nettype none
module rtcp_power_ctrl_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic        slow_clk_i = 1'b0, alarm_i = 1'b0, pulse = 1'b0, pin, wpo, oen;
  logic        core_on, bg_on, apor_on, sok, sys_rst, ck_out;
  logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata_o;
  int          n_mismatch = 0, n_compared = 0;
  localparam logic [15:0] PM = 16'h1930;
  // slow clock far faster than real, keeps the run short
  initial forever #2.5 clk_i = ~clk_i;
  initial forever #100 slow_clk_i = ~slow_clk_i;
  rtcp_power_ctrl #(.RAMP_CYCLES(8), .WAKE_CYCLES(4)) rtcp_power_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .slow_clk_i(slow_clk_i),
    .alarm_i(alarm_i), .wake_pin_i(pin), .wake_pin_o(wpo), .wake_pin_oe_n_o(oen),
    .core_regulator_output_o(core_on), .bandgap_on_o(bg_on), .analog_por_on_o(apor_on),
    .supply_ok_o(sok), .system_reset_o(sys_rst), .slow_clock_out_o(ck_out));
  rtcp_wake_partner rtcp_wake_partner_i (
    .clk_i(clk_i), .pulse_i(pulse), .dev_out_i(wpo), .dev_oe_n_i(oen), .pin_o(pin));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  // watch a window and report whether a signal was ever high
  // sel 0 watches the clock output, sel 1 the system reset pulse
  task automatic seen(input int n, input int sel, input logic exp);
    logic any;
    any = 1'b0;
    repeat (n) @(negedge clk_i) any = any | (sel ? sys_rst : ck_out);
    chk(16'(any), 16'(exp));
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    por_i <= 1'b0;
    rst_i <= 1'b0;
    rd(PM, 16'h0010);
    rd(16'h1934, 16'h0000);
    wr(PM, 16'hFFE9);
    rd(PM, 16'h0010);
    repeat (100) @(posedge clk_i);
    rd(PM, 16'h0009);
    chk(16'({oen, pin}), 16'h0000);
    seen(50, 0, 1'b1);
    @(posedge clk_i) rst_i <= 1'b1;
    @(posedge clk_i) rst_i <= 1'b0;
    rd(PM, 16'h0009);
    wr(PM, 16'h0010);
    repeat (100) @(posedge clk_i);
    seen(50, 0, 1'b0);
    chk(16'(oen), 16'h0001);
    // first pass regulator shutdown woken by the pin, second reference by alarm;
    // the pin stays an input in both passes
    for (int k = 0; k < 2; k++) begin
      wr(PM, k ? 16'h0014 : 16'h0012);
      repeat (100) @(posedge clk_i);
      chk(16'({core_on, sok, apor_on, bg_on}), k ? 16'h0000 : 16'h0001);
      rd(PM, 16'h0000);
      wr(PM, 16'h0011);
      if (k) alarm_i <= 1'b1;
      else pulse <= 1'b1;
      @(posedge clk_i) pulse <= 1'b0;
      seen(200, 1, 1'b1);
      chk(16'(sok), 16'h0001);
      @(posedge clk_i) alarm_i <= 1'b0;
      rd(PM, 16'h0010);
    end
    end_sim;
  end
  initial begin
    #50000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
endmodule // rtcp_power_ctrl_tb
`default_nettype wire

// ### rtcp_wake_partner.sv
/* external power circuit on the wake pin: drives it low, or high for a wake pulse.
   assumes the slow clock is scaled to 40 bus clocks per period. */
`timescale 1ns/1ps
`default_nettype none
module rtcp_wake_partner (
  input  wire logic clk_i,
  input  wire logic pulse_i,
  input  wire logic dev_out_i,
  input  wire logic dev_oe_n_i,
  output var  logic pin_o
);
  int hold_cnt = 0;
  // a full slow period so the device cannot miss the pulse
  always @(posedge clk_i) begin
    if (pulse_i) hold_cnt <= 40;
    else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
  end
  // wired level: the device can only pull low
  always_comb pin_o = (dev_oe_n_i | dev_out_i) & (hold_cnt > 0);
endmodule // rtcp_wake_partner
`default_nettype wire
